/* File: logic/spm_shared_pin_mux.sv */
// fixed-priority multiplexer for the fourteen shared port pins
// Function
// - after reset every shared pin is a port input, whatever is enabled
// - A0 order: analog 0, timer channel 0, keyboard wake 0, port bit
// - A1 order: analog 1, timer channel 1, keyboard wake 1, port bit
// - A2 order: external interrupt, timer clock, keyboard wake 2, port bit
// - A3 order: reset pin, keyboard wake 3, port bit
// - A4 order: oscillator output, analog 2, keyboard wake 4, port bit
// - A5 order: oscillator input, analog 3, keyboard wake 5, port bit
// - B0 order: analog 4, spi clock, port bit
// - B1 order: analog 5, spi mosi, port bit
// - B2 order: analog 6, spi miso, port bit
// - B3 order: analog 7, spi slave select, port bit
// - B4 order: analog 8, serial receive, port bit
// - B5 order: analog 9, serial transmit, port bit
// - B6: timer channel 2 beats port bit, either direction
// - B7: timer channel 3 beats port bit, either direction
// - serial transmit on B5 drives output only; port stays bidirectional
// - serial receive on B4 may drive or read; analog 8 is input only
// - analog selection never stops other functions driving the pin
`timescale 1ns/1ps
module spm_shared_pin_mux (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic [5:0] port_a_pin_i,
	output logic [5:0] port_a_pin_o,
	output logic [5:0] port_a_pin_oe_o,
	input wire logic [7:0] port_b_pin_i,
	output logic [7:0] port_b_pin_o,
	output logic [7:0] port_b_pin_oe_o,
	input wire logic [5:0] port_a_data_i,
	input wire logic [5:0] port_a_dir_i,
	output logic [5:0] port_a_in_o,
	input wire logic [7:0] port_b_data_i,
	input wire logic [7:0] port_b_dir_i,
	output logic [7:0] port_b_in_o,
	input wire logic [9:0] analog_en_i,
	output logic [9:0] analog_connect_o,
	input wire logic [3:0] timer_channel_en_i,
	input wire logic [3:0] timer_channel_oe_i,
	input wire logic [3:0] timer_channel_out_i,
	output logic [3:0] timer_channel_in_o,
	input wire logic timer_external_clock_en_i,
	output logic timer_external_clock_o,
	input wire logic [5:0] keyboard_wake_en_i,
	output logic [5:0] keyboard_wake_o,
	input wire logic ext_irq_en_i,
	output logic ext_irq_n_o,
	input wire logic reset_pin_en_i,
	output logic reset_pin_n_o,
	input wire logic oscillator_output_en_i,
	input wire logic oscillator_output_i,
	input wire logic oscillator_input_en_i,
	output logic oscillator_input_o,
	input wire logic [3:0] spi_en_i,
	input wire logic [3:0] spi_oe_i,
	input wire logic [3:0] spi_out_i,
	output logic [3:0] spi_in_o,
	input wire logic serial_rx_en_i,
	input wire logic serial_rx_oe_i,
	input wire logic serial_rx_out_i,
	output logic serial_rx_o,
	input wire logic serial_tx_en_i,
	input wire logic serial_tx_out_i,
	output logic [23:0] owner_a_o,
	output logic [31:0] owner_b_o
);
	// ownership among the non-analog functions; en[2] ranks highest
	function automatic logic [3:0] spm_owner(input logic run, input logic [2:0] en);
		logic [3:0] own;
		own = spm_pkg::OWN_PORT;
		if (!run)
			own = spm_pkg::OWN_PORT;
		else if (en[2])
			own = spm_pkg::OWN_HIGH;
		else if (en[1])
			own = spm_pkg::OWN_MID;
		else if (en[0])
			own = spm_pkg::OWN_LOW;
		return own;
	endfunction

	// drive of the pin by its owner: {output enable, output value}
	function automatic logic [1:0] spm_drive(
		input logic run,
		input logic [3:0] own,
		input logic [2:0] oe,
		input logic [2:0] val,
		input logic port_oe,
		input logic port_val
	);
		logic [3:0] drv;
		logic [3:0] lvl;
		drv = own & {oe, port_oe & run};
		lvl = {val, port_val};
		return {|drv, |(drv & lvl)};
	endfunction

	spm_pkg::spm_state_type state_q;
	spm_pkg::spm_state_type state_d;
	logic [1:0] hold_cnt_q;
	logic run;
	logic [5:0] a_sync;
	logic [7:0] b_sync;
	logic [2:0] a_en [0:5];
	logic [2:0] a_oe [0:5];
	logic [2:0] a_val [0:5];
	logic [2:0] b_en [0:7];
	logic [2:0] b_oe [0:7];
	logic [2:0] b_val [0:7];
	logic [3:0] a_own [0:5];
	logic [3:0] b_own [0:7];
	logic [5:0] a_oe_d;
	logic [5:0] a_out_d;
	logic [7:0] b_oe_d;
	logic [7:0] b_out_d;
	logic [23:0] owner_a_d;
	logic [31:0] owner_b_d;
	logic [5:0] a_oe_q;
	logic [5:0] a_out_q;
	logic [7:0] b_oe_q;
	logic [7:0] b_out_q;
	logic [23:0] owner_a_q;
	logic [31:0] owner_b_q;
	logic [5:0] a_in_q;
	logic [7:0] b_in_q;
	logic [9:0] analog_q;
	logic [3:0] timer_in_q;
	logic timer_external_clock_q;
	logic [5:0] kbd_q;
	logic irq_n_q;
	logic rst_n_q;
	logic osc_in_q;
	logic [3:0] spi_in_q;
	logic rx_q;

	spm_pin_sync #(
		.WIDTH(spm_pkg::PORT_A_WIDTH)
	) u_sync_a (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.pin_i(port_a_pin_i),
		.level_o(a_sync)
	);

	spm_pin_sync #(
		.WIDTH(spm_pkg::PORT_B_WIDTH)
	) u_sync_b (
		.mclk_i(mclk_i),
		.nrst_i(nrst_i),
		.pin_i(port_b_pin_i),
		.level_o(b_sync)
	);

	// pins stay inputs until the synchronisers have filled after reset
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			spm_pkg::ST_HOLD:
				if (hold_cnt_q == spm_pkg::HOLD_CYCLES)
					state_d = spm_pkg::ST_RUN;
			spm_pkg::ST_RUN:
				state_d = spm_pkg::ST_RUN;
			default:
				state_d = spm_pkg::ST_HOLD;
		endcase
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_q <= spm_pkg::ST_HOLD;
			hold_cnt_q <= 2'h0;
		end
		else
		begin
			state_q <= state_d;
			if (state_q == spm_pkg::ST_HOLD)
				hold_cnt_q <= hold_cnt_q + 2'h1;
		end
	end

	assign run = (state_q == spm_pkg::ST_RUN);

	// ranked non-analog functions per pin; analog sits outside the chain
	always_comb
	begin
		a_en[0] = {timer_channel_en_i[0], keyboard_wake_en_i[0], 1'b0};
		a_oe[0] = {timer_channel_oe_i[0], 2'h0};
		a_val[0] = {timer_channel_out_i[0], 2'h0};
		a_en[1] = {timer_channel_en_i[1], keyboard_wake_en_i[1], 1'b0};
		a_oe[1] = {timer_channel_oe_i[1], 2'h0};
		a_val[1] = {timer_channel_out_i[1], 2'h0};
		a_en[2] = {ext_irq_en_i, timer_external_clock_en_i, keyboard_wake_en_i[2]};
		a_oe[2] = 3'h0;
		a_val[2] = 3'h0;
		a_en[3] = {reset_pin_en_i, keyboard_wake_en_i[3], 1'b0};
		a_oe[3] = 3'h0;
		a_val[3] = 3'h0;
		a_en[4] = {oscillator_output_en_i, keyboard_wake_en_i[4], 1'b0};
		a_oe[4] = 3'h4;
		a_val[4] = {oscillator_output_i, 2'h0};
		a_en[5] = {oscillator_input_en_i, keyboard_wake_en_i[5], 1'b0};
		a_oe[5] = 3'h0;
		a_val[5] = 3'h0;
		for (int k = 0; k < spm_pkg::SPI_COUNT; k++)
		begin
			b_en[k] = {spi_en_i[k], 2'h0};
			b_oe[k] = {spi_oe_i[k], 2'h0};
			b_val[k] = {spi_out_i[k], 2'h0};
		end
		b_en[4] = {serial_rx_en_i, 2'h0};
		b_oe[4] = {serial_rx_oe_i, 2'h0};
		b_val[4] = {serial_rx_out_i, 2'h0};
		b_en[5] = {serial_tx_en_i, 2'h0};
		b_oe[5] = 3'h4;
		b_val[5] = {serial_tx_out_i, 2'h0};
		b_en[6] = {timer_channel_en_i[2], 2'h0};
		b_oe[6] = {timer_channel_oe_i[2], 2'h0};
		b_val[6] = {timer_channel_out_i[2], 2'h0};
		b_en[7] = {timer_channel_en_i[3], 2'h0};
		b_oe[7] = {timer_channel_oe_i[3], 2'h0};
		b_val[7] = {timer_channel_out_i[3], 2'h0};
	end

	// the analog switch never masks the drive of lower functions
	always_comb
	begin
		for (int i = 0; i < spm_pkg::PORT_A_WIDTH; i++)
		begin
			a_own[i] = spm_owner(run, a_en[i]);
			{a_oe_d[i], a_out_d[i]} = spm_drive(run, a_own[i], a_oe[i], a_val[i],
				port_a_dir_i[i], port_a_data_i[i]);
			owner_a_d[4*i +: 4] = a_own[i];
		end
		for (int i = 0; i < spm_pkg::PORT_B_WIDTH; i++)
		begin
			b_own[i] = spm_owner(run, b_en[i]);
			{b_oe_d[i], b_out_d[i]} = spm_drive(run, b_own[i], b_oe[i], b_val[i],
				port_b_dir_i[i], port_b_data_i[i]);
			owner_b_d[4*i +: 4] = b_own[i];
		end
	end

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			a_oe_q <= spm_pkg::PORT_A_OE_RESET;
			a_out_q <= spm_pkg::PORT_A_OUT_RESET;
			b_oe_q <= spm_pkg::PORT_B_OE_RESET;
			b_out_q <= spm_pkg::PORT_B_OUT_RESET;
			owner_a_q <= spm_pkg::OWNER_A_RESET;
			owner_b_q <= spm_pkg::OWNER_B_RESET;
		end
		else
		begin
			a_oe_q <= a_oe_d;
			a_out_q <= a_out_d;
			b_oe_q <= b_oe_d;
			b_out_q <= b_out_d;
			owner_a_q <= owner_a_d;
			owner_b_q <= owner_b_d;
		end
	end

	// analog input 2 and 3 lose the pin to the oscillator
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			analog_q <= 10'h000;
		else if (!run)
			analog_q <= 10'h000;
		else
		begin
			analog_q[1:0] <= analog_en_i[1:0];
			analog_q[2] <= analog_en_i[2] & ~oscillator_output_en_i;
			analog_q[3] <= analog_en_i[3] & ~oscillator_input_en_i;
			analog_q[9:4] <= analog_en_i[9:4];
		end
	end

	// pin levels handed to the function that owns each pin
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			a_in_q <= 6'h00;
			b_in_q <= 8'h00;
			timer_in_q <= 4'h0;
			timer_external_clock_q <= 1'b0;
			kbd_q <= 6'h00;
			irq_n_q <= 1'b1;
			rst_n_q <= 1'b1;
			osc_in_q <= 1'b0;
			spi_in_q <= spm_pkg::SPI_IN_RESET;
			rx_q <= 1'b0;
		end
		else
		begin
			a_in_q <= a_sync;
			b_in_q <= b_sync;
			timer_in_q[0] <= (a_own[0] == spm_pkg::OWN_HIGH) & a_sync[0];
			timer_in_q[1] <= (a_own[1] == spm_pkg::OWN_HIGH) & a_sync[1];
			timer_in_q[2] <= (b_own[6] == spm_pkg::OWN_HIGH) & b_sync[6];
			timer_in_q[3] <= (b_own[7] == spm_pkg::OWN_HIGH) & b_sync[7];
			irq_n_q <= (a_own[2] == spm_pkg::OWN_HIGH) ? a_sync[2] : 1'b1;
			timer_external_clock_q <= (a_own[2] == spm_pkg::OWN_MID) & a_sync[2];
			kbd_q[2] <= (a_own[2] == spm_pkg::OWN_LOW) & a_sync[2];
			rst_n_q <= (a_own[3] == spm_pkg::OWN_HIGH) ? a_sync[3] : 1'b1;
			osc_in_q <= (a_own[5] == spm_pkg::OWN_HIGH) & a_sync[5];
			kbd_q[0] <= (a_own[0] == spm_pkg::OWN_MID) & a_sync[0];
			kbd_q[1] <= (a_own[1] == spm_pkg::OWN_MID) & a_sync[1];
			kbd_q[3] <= (a_own[3] == spm_pkg::OWN_MID) & a_sync[3];
			kbd_q[4] <= (a_own[4] == spm_pkg::OWN_MID) & a_sync[4];
			kbd_q[5] <= (a_own[5] == spm_pkg::OWN_MID) & a_sync[5];
			for (int k = 0; k < spm_pkg::SPI_COUNT; k++)
			begin
				if (b_own[k] == spm_pkg::OWN_HIGH)
					spi_in_q[k] <= b_sync[k];
				else
					spi_in_q[k] <= spm_pkg::SPI_IN_RESET[k];
			end
			rx_q <= (b_own[4] == spm_pkg::OWN_HIGH) & b_sync[4];
		end
	end

	assign port_a_pin_o = a_out_q;
	assign port_a_pin_oe_o = a_oe_q;
	assign port_b_pin_o = b_out_q;
	assign port_b_pin_oe_o = b_oe_q;
	assign port_a_in_o = a_in_q;
	assign port_b_in_o = b_in_q;
	assign analog_connect_o = analog_q;
	assign timer_channel_in_o = timer_in_q;
	assign timer_external_clock_o = timer_external_clock_q;
	assign keyboard_wake_o = kbd_q;
	assign ext_irq_n_o = irq_n_q;
	assign reset_pin_n_o = rst_n_q;
	assign oscillator_input_o = osc_in_q;
	assign spi_in_o = spi_in_q;
	assign serial_rx_o = rx_q;
	assign owner_a_o = owner_a_q;
	assign owner_b_o = owner_b_q;
endmodule

/* File: logic/spm_pkg.sv */
// shared constants and types for the shared pin priority multiplexer
package spm_pkg;
	localparam int PORT_A_WIDTH = 6;
	localparam int PORT_B_WIDTH = 8;
	localparam int ANALOG_COUNT = 10;
	localparam int TIMER_COUNT = 4;
	localparam int KBD_COUNT = 6;
	localparam int SPI_COUNT = 4;

	// index of each serial peripheral line inside the spi vectors
	localparam int SPI_SCK = 0;
	localparam int SPI_MOSI = 1;
	localparam int SPI_MISO = 2;
	localparam int SPI_SS_N = 3;

	// one-hot ownership codes of a pin: three ranked functions above the port bit
	localparam logic [3:0] OWN_PORT = 4'h1;
	localparam logic [3:0] OWN_LOW = 4'h2;
	localparam logic [3:0] OWN_MID = 4'h4;
	localparam logic [3:0] OWN_HIGH = 4'h8;

	// last hold count with every pin forced to input after reset release; the hold lasts four cycles
	localparam logic [1:0] HOLD_CYCLES = 2'h3;

	// values after reset
	localparam logic [5:0] PORT_A_OE_RESET = 6'h00;
	localparam logic [5:0] PORT_A_OUT_RESET = 6'h00;
	localparam logic [7:0] PORT_B_OE_RESET = 8'h00;
	localparam logic [7:0] PORT_B_OUT_RESET = 8'h00;
	localparam logic [3:0] SPI_IN_RESET = 4'h8;
	localparam logic [23:0] OWNER_A_RESET = 24'h111111;
	localparam logic [31:0] OWNER_B_RESET = 32'h11111111;
	localparam logic SYNC_RESET = 1'b0;

	typedef enum logic [1:0]
	{
		ST_HOLD = 2'h1,
		ST_RUN = 2'h2
	} spm_state_type;
endpackage

/* File: logic/spm_pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module spm_pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;
	logic [WIDTH-1:0] level_q;

	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			meta_q <= {WIDTH{spm_pkg::SYNC_RESET}};
			s2_q <= {WIDTH{spm_pkg::SYNC_RESET}};
			s3_q <= {WIDTH{spm_pkg::SYNC_RESET}};
		end
		else
		begin
			meta_q <= pin_i;
			s2_q <= meta_q;
			s3_q <= s2_q;
		end
	end

	// a bit changes only once the second and third stages agree
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			level_q <= {WIDTH{spm_pkg::SYNC_RESET}};
		else
			level_q <= (s2_q & s3_q) | (level_q & (s2_q ^ s3_q));
	end

	assign level_o = level_q;
endmodule

/* File: tb/spm_mux_properties.sv */
// concurrent checks on the shared pin multiplexer ports
`timescale 1ns/1ps
module spm_mux_props (
	input wire logic mclk_i,
	input wire logic nrst_i,
	input wire logic [7:0] port_b_pin_i,
	input wire logic [7:0] port_b_pin_o,
	input wire logic [7:0] port_b_pin_oe_o,
	input wire logic [5:0] port_a_pin_oe_o,
	input wire logic [7:0] port_b_in_o,
	input wire logic [9:0] analog_en_i,
	input wire logic [3:0] timer_channel_en_i,
	input wire logic [3:0] timer_channel_oe_i,
	input wire logic [3:0] timer_channel_out_i,
	input wire logic [5:0] keyboard_wake_en_i,
	input wire logic ext_irq_en_i,
	input wire logic timer_external_clock_en_i,
	input wire logic reset_pin_en_i,
	input wire logic oscillator_output_en_i,
	input wire logic oscillator_input_en_i,
	input wire logic [3:0] spi_en_i,
	input wire logic serial_rx_en_i,
	input wire logic serial_rx_oe_i,
	input wire logic serial_tx_en_i,
	input wire logic serial_tx_out_i,
	input wire logic [23:0] owner_a_o,
	input wire logic [31:0] owner_b_o
);
	logic [2:0] edges_q;
	logic run;
	logic [23:0] exp_a;
	logic [31:0] exp_b;
	function automatic logic [3:0] rk(input logic h, input logic m, input logic l);
		return h ? 4'h8 : m ? 4'h4 : l ? 4'h2 : 4'h1;
	endfunction
	// edges since reset release, saturating once the hold is long over
	always_ff @(posedge mclk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			edges_q <= 3'h0;
		else if (edges_q != 3'h7)
			edges_q <= edges_q + 3'h1;
	end
	assign run = edges_q == 3'h7;
	assign exp_a = {rk(oscillator_input_en_i, keyboard_wake_en_i[5], 1'b0),
		rk(oscillator_output_en_i, keyboard_wake_en_i[4], 1'b0),
		rk(reset_pin_en_i, keyboard_wake_en_i[3], 1'b0),
		rk(ext_irq_en_i, timer_external_clock_en_i, keyboard_wake_en_i[2]),
		rk(timer_channel_en_i[1], keyboard_wake_en_i[1], 1'b0),
		rk(timer_channel_en_i[0], keyboard_wake_en_i[0], 1'b0)};
	assign exp_b = {rk(timer_channel_en_i[3], 1'b0, 1'b0), rk(timer_channel_en_i[2], 1'b0, 1'b0),
		rk(serial_tx_en_i, 1'b0, 1'b0), rk(serial_rx_en_i, 1'b0, 1'b0),
		rk(spi_en_i[3], 1'b0, 1'b0), rk(spi_en_i[2], 1'b0, 1'b0),
		rk(spi_en_i[1], 1'b0, 1'b0), rk(spi_en_i[0], 1'b0, 1'b0)};
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	property p_hold;
		edges_q < 3'h5 |-> port_a_pin_oe_o == 6'h00 && port_b_pin_oe_o == 8'h00
			&& owner_a_o == spm_pkg::OWNER_A_RESET && owner_b_o == spm_pkg::OWNER_B_RESET;
	endproperty
	a_hold: assert property (p_hold)
		else $error("pin not held as input after reset");
	property p_own_a;
		run |=> owner_a_o == $past(exp_a);
	endproperty
	a_own_a: assert property (p_own_a)
		else $error("port a owner wrong");
	property p_own_b;
		run |=> owner_b_o == $past(exp_b);
	endproperty
	a_own_b: assert property (p_own_b)
		else $error("port b owner wrong");
	property p_timer_b;
		run && timer_channel_en_i[3:2] == 2'h3 |=> port_b_pin_oe_o[7:6] ==
			$past(timer_channel_oe_i[3:2]) && (port_b_pin_o[7:6] & port_b_pin_oe_o[7:6]) ==
			($past(timer_channel_out_i[3:2]) & $past(timer_channel_oe_i[3:2]));
	endproperty
	a_timer_b: assert property (p_timer_b)
		else $error("timer drive on port b wrong");
	property p_tx;
		run && serial_tx_en_i |=> port_b_pin_oe_o[5] && port_b_pin_o[5] == $past(serial_tx_out_i);
	endproperty
	a_tx: assert property (p_tx)
		else $error("transmit pin not driven");
	property p_rx;
		run && serial_rx_en_i |=> port_b_pin_oe_o[4] == $past(serial_rx_oe_i);
	endproperty
	a_rx: assert property (p_rx)
		else $error("receive pin direction wrong");
	property p_analog;
		run && analog_en_i[0] && timer_channel_en_i[0] |=>
			port_a_pin_oe_o[0] == $past(timer_channel_oe_i[0]);
	endproperty
	a_analog: assert property (p_analog)
		else $error("analog select stopped timer drive");
	property p_read;
		(run && $stable(port_b_pin_i)) [*6] |-> port_b_in_o == port_b_pin_i;
	endproperty
	a_read: assert property (p_read)
		else $error("pin level not returned");
	c_tx: cover property (run && serial_tx_en_i);
	c_timer: cover property (run && timer_channel_en_i == 4'hf);
	c_read: cover property ((run && $stable(port_b_pin_i)) [*6]);
endmodule

bind spm_shared_pin_mux spm_mux_props spm_mux_props_i (.*);

/* File: tb/spm_board_pins.sv */
// board side of the shared pins: drives each pin unless the device drives it
`timescale 1ns/1ps
module spm_board_pins #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] dev_oe_i,
	input wire logic [WIDTH-1:0] dev_out_i,
	input wire logic [WIDTH-1:0] board_i,
	output logic [WIDTH-1:0] pin_o
);
	// the board yields wherever the device output enable is high
	assign pin_o = (dev_oe_i & dev_out_i) | (~dev_oe_i & board_i);
endmodule

/* File: tb/spm_shared_pin_mux_tb.sv */
// self-checking bench for the shared pin multiplexer
`timescale 1ns/1ps
module spm_shared_pin_mux_tb;
	logic mclk_i, nrst_i, timer_external_clock_en_i, timer_external_clock_o, ext_irq_en_i;
	logic ext_irq_n_o, reset_pin_en_i, reset_pin_n_o, oscillator_output_en_i;
	logic oscillator_output_i, oscillator_input_en_i, oscillator_input_o, serial_rx_en_i;
	logic serial_rx_oe_i, serial_rx_out_i, serial_rx_o, serial_tx_en_i, serial_tx_out_i;
	logic [5:0] port_a_pin_i, port_a_pin_o, port_a_pin_oe_o, port_a_data_i, port_a_dir_i;
	logic [5:0] port_a_in_o, keyboard_wake_en_i, keyboard_wake_o, ext_a;
	logic [7:0] port_b_pin_i, port_b_pin_o, port_b_pin_oe_o, port_b_data_i, port_b_dir_i;
	logic [7:0] port_b_in_o, ext_b;
	logic [3:0] timer_channel_en_i, timer_channel_oe_i, timer_channel_out_i, timer_channel_in_o;
	logic [3:0] spi_en_i, spi_oe_i, spi_out_i, spi_in_o;
	logic [9:0] analog_en_i, analog_connect_o;
	logic [23:0] owner_a_o;
	logic [31:0] owner_b_o;
	int num_errors, samples_checked, cycles;
	spm_shared_pin_mux spm_shared_pin_mux_i (.*);
	spm_board_pins #(.WIDTH(6)) spm_board_pins_i (.dev_oe_i(port_a_pin_oe_o),
		.dev_out_i(port_a_pin_o), .board_i(ext_a), .pin_o(port_a_pin_i));
	spm_board_pins #(.WIDTH(8)) spm_board_pins_b_i (.dev_oe_i(port_b_pin_oe_o),
		.dev_out_i(port_b_pin_o), .board_i(ext_b), .pin_o(port_b_pin_i));
	always #2.5 mclk_i = ~mclk_i;
	always @(posedge mclk_i)
	begin
		cycles++;
		if (cycles == 1000)
		begin
			num_errors++;
			tally_and_finish();
		end
	end
	function automatic logic [3:0] own(input logic h, input logic m, input logic l);
		return h ? 4'h8 : m ? 4'h4 : l ? 4'h2 : 4'h1;
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic check_hold();
		repeat (3) @(negedge mclk_i);
		chk("a oe in hold", 32'(port_a_pin_oe_o), 32'h0);
		chk("b oe in hold", 32'(port_b_pin_oe_o), 32'h0);
		chk("a owner in hold", 32'(owner_a_o), 32'(spm_pkg::OWNER_A_RESET));
		repeat (4) @(negedge mclk_i);
	endtask
	task automatic check_priority();
		logic [3:0] k;
		logic [7:0] boe;
		logic [7:0] bout;
		logic [5:0] aoe;
		for (int n = 0; n < 16; n++)
		begin
			k = 4'(n);
			{timer_channel_en_i, timer_channel_oe_i, timer_channel_out_i} = {k, k ^ 4'h4, ~k};
			keyboard_wake_en_i = {k[1:0], ~k};
			{ext_irq_en_i, timer_external_clock_en_i, reset_pin_en_i} = k[2:0];
			{oscillator_output_en_i, oscillator_input_en_i, oscillator_output_i} = k[3:1];
			{spi_en_i, spi_oe_i, spi_out_i} = {~k, k ^ 4'h3, k ^ 4'h9};
			{serial_rx_en_i, serial_rx_oe_i, serial_tx_en_i, serial_rx_out_i} = k;
			serial_tx_out_i = ~k[1];
			{port_b_dir_i, port_b_data_i, port_a_dir_i} = {k, ~k, ~k, k, k[1:0], k};
			{analog_en_i, port_a_data_i} = {k, k, k[1:0], ~k, k[1:0]};
			boe = port_b_dir_i;
			bout = port_b_data_i;
			for (int i = 0; i < 4; i++)
				if (spi_en_i[i])
					{boe[i], bout[i]} = {spi_oe_i[i], spi_out_i[i]};
			if (serial_rx_en_i)
				{boe[4], bout[4]} = {serial_rx_oe_i, serial_rx_out_i};
			if (serial_tx_en_i)
				{boe[5], bout[5]} = {1'b1, serial_tx_out_i};
			for (int i = 2; i < 4; i++)
				if (timer_channel_en_i[i])
					{boe[i+4], bout[i+4]} = {timer_channel_oe_i[i], timer_channel_out_i[i]};
			@(negedge mclk_i);
			chk("a owner", 32'(owner_a_o), {8'h00, own(k[2], k[1], 1'b0), own(k[3], k[0], 1'b0),
				own(k[0], ~k[3], 1'b0), own(k[2], k[1], ~k[2]), own(k[1], ~k[1], 1'b0),
				own(k[0], ~k[0], 1'b0)});
			chk("b owner", owner_b_o, {own(k[3], 1'b0, 1'b0), own(k[2], 1'b0, 1'b0),
				own(k[1], 1'b0, 1'b0), own(k[3], 1'b0, 1'b0), own(~k[3], 1'b0, 1'b0),
				own(~k[2], 1'b0, 1'b0), own(~k[1], 1'b0, 1'b0), own(~k[0], 1'b0, 1'b0)});
			chk("b oe", 32'(port_b_pin_oe_o), 32'(boe));
			chk("b out", 32'(port_b_pin_o & boe), 32'(bout & boe));
			chk("a0 oe", 32'(port_a_pin_oe_o[0]), 32'(k[0] ? timer_channel_oe_i[0] : 1'b0));
			aoe = {1'b0, k[3], ~k[0] & k[3], 1'b0, k[1:0]};
			chk("a oe", 32'(port_a_pin_oe_o), 32'(aoe));
			chk("a out", 32'(port_a_pin_o & aoe),
				32'({1'b0, k[3] & k[1], ~k[0] & k[3] & ~k[1], 3'h0}));
			chk("analog", 32'(analog_connect_o),
				32'({k, k[3:2], k[1] & ~k[2], k[0] & ~k[3], k[1:0]}));
		end
	endtask
	task automatic check_pin_read();
		{timer_channel_en_i, timer_channel_oe_i, spi_en_i, keyboard_wake_en_i} = 18'h3003f;
		spi_oe_i = 4'h0;
		{serial_rx_en_i, serial_rx_oe_i, serial_tx_en_i, ext_irq_en_i} = 4'h8;
		{timer_external_clock_en_i, reset_pin_en_i, oscillator_output_en_i} = 3'h0;
		{oscillator_input_en_i, port_a_dir_i, port_b_dir_i} = 15'h0000;
		{ext_a, ext_b} = {6'h2d, 8'h96};
		repeat (7) @(negedge mclk_i);
		chk("b level", 32'(port_b_in_o), 32'h96);
		chk("a level", 32'(port_a_in_o), 32'h2d);
		chk("keyboard wake", 32'(keyboard_wake_o), 32'h2d);
		chk("timer in", 32'(timer_channel_in_o[3:2]), 32'h2);
		chk("receive in", 32'(serial_rx_o), 32'h1);
		chk("idle ins", 32'({timer_external_clock_o, ext_irq_n_o, reset_pin_n_o,
			oscillator_input_o, spi_in_o}), 32'h68);
		// hand the pins to the input functions; the pins themselves stay put
		{timer_channel_en_i, spi_en_i} = 8'hff;
		{timer_external_clock_en_i, reset_pin_en_i, oscillator_input_en_i} = 3'h7;
		@(negedge mclk_i);
		chk("owned ins", 32'({timer_external_clock_o, ext_irq_n_o, reset_pin_n_o,
			oscillator_input_o, spi_in_o, timer_channel_in_o}), 32'hf69);
		chk("wake lost", 32'(keyboard_wake_o), 32'h00);
	endtask
	task automatic check_reset_mid_run();
		port_b_dir_i = 8'hff;
		@(negedge mclk_i);
		chk("b oe before reset", 32'(port_b_pin_oe_o), 32'h20);
		nrst_i = 1'b0;
		@(negedge mclk_i);
		chk("b oe in reset", 32'(port_b_pin_oe_o), 32'h0);
		chk("b owner in reset", owner_b_o, spm_pkg::OWNER_B_RESET);
		nrst_i = 1'b1;
		check_hold();
		chk("b oe after hold", 32'(port_b_pin_oe_o), 32'h20);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial
	begin
		{mclk_i, nrst_i, num_errors, samples_checked, cycles} = '0;
		{port_a_data_i, port_a_dir_i, port_b_data_i, port_b_dir_i, ext_a, ext_b} = '1;
		{analog_en_i, timer_channel_en_i, timer_channel_oe_i, timer_channel_out_i} = '1;
		{timer_external_clock_en_i, keyboard_wake_en_i, ext_irq_en_i, reset_pin_en_i} = '1;
		{oscillator_output_en_i, oscillator_output_i, oscillator_input_en_i} = '1;
		{spi_en_i, spi_oe_i, spi_out_i, serial_rx_en_i, serial_rx_oe_i, serial_rx_out_i} = '1;
		{serial_tx_en_i, serial_tx_out_i} = '1;
		repeat (2) @(negedge mclk_i);
		nrst_i = 1'b1;
		check_hold();
		check_priority();
		check_pin_read();
		check_reset_mid_run();
		tally_and_finish();
	end
endmodule
